// >>> hdl/external_bus_pin_interface.sv
// module: external bus pin driver with wait stretch and bus hold handshake
// How it works
// - read strobe goes low in the data phase of every external read cycle.
// - low write strobe pulses when writing the lower data byte.
// - upper write strobe pulses when writing the upper data byte.
// - wait input held low stretches the current bus cycle.
// - float all bus and select pins first, then pull grant low.
// - direction output high for read and dummy cycles, low for writes.
// - row strobe latches the row address during dram accesses.
// - select zero goes low while the address is inside its area.
// - in dram mode select zero pin carries the column strobe instead.
// - outside master must not reach internal memory; such accesses unserved.
// - selects one and two behave alike, with column strobes in dram mode.
`timescale 1ns/1ps
module external_bus_pin_interface #(
	parameter logic [ext_bus_pkg::WAIT_W-1:0] WAIT_CYCLES = ext_bus_pkg::WAIT_DEFAULT
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// configuration
	input wire logic [ext_bus_pkg::NUM_SEL-1:0] dram_mode,
	// internal request side
	input wire logic req_valid,
	input wire ext_bus_pkg::bus_req_type req,
	output logic req_ready,
	output logic done,
	output logic [ext_bus_pkg::DATA_W-1:0] rdata,
	// outside pins
	input wire logic wait_n,
	input wire logic bus_hold_request_n,
	output logic bus_hold_grant_n,
	output ext_bus_pkg::strobe_type strobe,
	output logic strobe_oe,
	output logic [ext_bus_pkg::ADDR_W-1:0] address_lines,
	output logic address_oe,
	input wire logic [ext_bus_pkg::DATA_W-1:0] muxed_addr_data_bus_in,
	output logic [ext_bus_pkg::DATA_W-1:0] muxed_addr_data_bus_out,
	output logic muxed_addr_data_bus_oe,
	// internal access attempted by outside master while granted
	input wire logic [ext_bus_pkg::ADDR_W-1:0] foreign_addr,
	input wire logic foreign_valid,
	output logic foreign_refused
);
	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_FLOAT,
		ST_HELD
	} state_type;

	state_type state;
	ext_bus_pkg::bus_req_type cur;
	logic [ext_bus_pkg::WAIT_W-1:0] wait_cnt;
	logic [2:0] wait_sync;
	logic [2:0] hold_sync;
	logic wait_level;
	logic hold_level;
	logic [ext_bus_pkg::NUM_SEL-1:0] in_area;
	logic [ext_bus_pkg::ADDR_W-1:0] area_base [ext_bus_pkg::NUM_SEL];
	logic [ext_bus_pkg::ADDR_W-1:0] area_mask [ext_bus_pkg::NUM_SEL];
	logic is_dram;

	assign area_base[0] = ext_bus_pkg::AREA_BASE_0;
	assign area_base[1] = ext_bus_pkg::AREA_BASE_1;
	assign area_base[2] = ext_bus_pkg::AREA_BASE_2;
	assign area_mask[0] = ext_bus_pkg::AREA_MASK_0;
	assign area_mask[1] = ext_bus_pkg::AREA_MASK_1;
	assign area_mask[2] = ext_bus_pkg::AREA_MASK_2;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// a change counts once the second and third stages agree
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wait_sync <= 3'h7;
			hold_sync <= 3'h7;
			wait_level <= 1'b1;
			hold_level <= 1'b1;
		end else if (clk_en) begin
			wait_sync <= {wait_sync[1:0], wait_n};
			hold_sync <= {hold_sync[1:0], bus_hold_request_n};
			if (wait_sync[1] == wait_sync[2]) begin
				wait_level <= wait_sync[2];
			end
			if (hold_sync[1] == hold_sync[2]) begin
				hold_level <= hold_sync[2];
			end
		end
	end

	// ------------------------------------------------------------
	// area decode
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < ext_bus_pkg::NUM_SEL; gi++) begin : g_area
			assign in_area[gi] = ((cur.addr & area_mask[gi]) == area_base[gi]);
		end
	endgenerate
	assign is_dram = |(in_area & dram_mode);

	// ------------------------------------------------------------
	// cycle sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			cur <= '0;
			wait_cnt <= '0;
		end else if (clk_en) begin
			case (state)
				ST_IDLE: begin
					if (!hold_level) begin
						state <= ST_FLOAT;
					end else if (req_valid) begin
						cur <= req;
						state <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					wait_cnt <= WAIT_CYCLES;
					state <= ST_DATA;
				end
				ST_DATA: begin
					if (wait_cnt != '0) begin
						wait_cnt <= wait_cnt - 1'b1;
					end else if (wait_level) begin
						state <= ST_IDLE;
					end
				end
				ST_FLOAT: begin
					state <= ST_HELD;
				end
				ST_HELD: begin
					if (hold_level) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// strobes and direction
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			strobe <= ext_bus_pkg::STROBE_IDLE;
		end else if (clk_en) begin
			strobe <= ext_bus_pkg::STROBE_IDLE;
			if (state == ST_ADDR || state == ST_DATA) begin
				strobe.dir_read <= (cur.kind != ext_bus_pkg::CYC_WRITE);
				for (int i = 0; i < ext_bus_pkg::NUM_SEL; i++) begin
					// dram selects carry column strobe in data phase only
					if (dram_mode[i]) begin
						strobe.select_n[i] <= !(in_area[i] && state == ST_DATA);
					end else begin
						strobe.select_n[i] <= !in_area[i];
					end
				end
				strobe.row_strobe_n <= !is_dram;
			end
			if (state == ST_DATA && cur.kind == ext_bus_pkg::CYC_READ) begin
				strobe.read_n <= 1'b0;
			end
			if (state == ST_DATA && cur.kind == ext_bus_pkg::CYC_WRITE) begin
				strobe.write_lo_n <= !cur.byte_en[0];
				strobe.upper_byte_write_strobe_n <= !cur.byte_en[1];
			end
		end
	end

	// ------------------------------------------------------------
	// pin drive and handshake
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			strobe_oe <= 1'b1;
			address_oe <= 1'b1;
			muxed_addr_data_bus_oe <= 1'b0;
			bus_hold_grant_n <= 1'b1;
			address_lines <= '0;
			muxed_addr_data_bus_out <= '0;
		end else if (clk_en) begin
			// enables drop a cycle before grant, so no overlap with the outside master
			strobe_oe <= (state != ST_FLOAT && state != ST_HELD);
			address_oe <= (state != ST_FLOAT && state != ST_HELD);
			bus_hold_grant_n <= !(state == ST_HELD && !hold_level);
			address_lines <= cur.addr;
			if (state == ST_ADDR) begin
				muxed_addr_data_bus_out <= cur.addr[ext_bus_pkg::DATA_W-1:0];
				muxed_addr_data_bus_oe <= 1'b1;
			end else if (state == ST_DATA && cur.kind == ext_bus_pkg::CYC_WRITE) begin
				muxed_addr_data_bus_out <= cur.wdata;
				muxed_addr_data_bus_oe <= 1'b1;
			end else begin
				muxed_addr_data_bus_oe <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// request side answers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			req_ready <= 1'b0;
			done <= 1'b0;
			rdata <= '0;
			foreign_refused <= 1'b0;
		end else if (clk_en) begin
			req_ready <= (state == ST_IDLE) && hold_level && !req_valid;
			done <= 1'b0;
			if (state == ST_DATA && wait_cnt == '0 && wait_level) begin
				done <= 1'b1;
				if (cur.kind == ext_bus_pkg::CYC_READ) begin
					rdata <= muxed_addr_data_bus_in;
				end
			end
			// internal space is never served to the outside master
			foreign_refused <= (state == ST_HELD) && foreign_valid &&
				(foreign_addr < ext_bus_pkg::INTERNAL_LIMIT);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_read_strobe_kind: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!strobe.read_n |-> strobe.dir_read)
		else $error("read strobe during write cycle");
	a_write_lo_dir: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!strobe.write_lo_n |-> !strobe.dir_read)
		else $error("low write strobe without write direction");
	a_write_hi_dir: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!strobe.upper_byte_write_strobe_n |-> !strobe.dir_read && strobe.read_n)
		else $error("upper write strobe outside write cycle");
	a_wait_stretch: assert property (@(posedge clk_sys) disable iff (!reset_n || !clk_en)
		(state == ST_DATA && wait_cnt == '0 && !wait_level) |=> state == ST_DATA)
		else $error("cycle ended while wait held");
	a_float_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!bus_hold_grant_n |-> !strobe_oe && !address_oe && !muxed_addr_data_bus_oe)
		else $error("grant while pins still driven");
	a_grant_after_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(bus_hold_grant_n) |-> $past(state) == ST_HELD && !$past(hold_level))
		else $error("grant without request");
	a_direction_write: assert property (@(posedge clk_sys) disable iff (!reset_n || !clk_en)
		(state == ST_DATA && cur.kind == ext_bus_pkg::CYC_WRITE) |=> !strobe.dir_read)
		else $error("direction high during write");
	a_select_area: assert property (@(posedge clk_sys) disable iff (!reset_n || !clk_en)
		(state == ST_ADDR && !dram_mode[0]) |=> strobe.select_n[0] == !$past(in_area[0]))
		else $error("select zero mismatches area");
	a_column_late: assert property (@(posedge clk_sys) disable iff (!reset_n || !clk_en)
		(state == ST_ADDR && dram_mode[0]) |=> strobe.select_n[0])
		else $error("column strobe in address phase");
endmodule : external_bus_pin_interface

// >>> include/ext_bus_pkg.sv
// package: constants and carrier types for the external bus pin interface
package ext_bus_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int NUM_SEL = 3;
	localparam int WAIT_W = 4;
	localparam logic [WAIT_W-1:0] WAIT_DEFAULT = 4'h1;
	localparam logic [ADDR_W-1:0] AREA_BASE_0 = 24'h01_0000;
	localparam logic [ADDR_W-1:0] AREA_MASK_0 = 24'hFF_0000;
	localparam logic [ADDR_W-1:0] AREA_BASE_1 = 24'h20_0000;
	localparam logic [ADDR_W-1:0] AREA_MASK_1 = 24'hF0_0000;
	localparam logic [ADDR_W-1:0] AREA_BASE_2 = 24'h80_0000;
	localparam logic [ADDR_W-1:0] AREA_MASK_2 = 24'h80_0000;
	localparam logic [ADDR_W-1:0] INTERNAL_LIMIT = 24'h00_1000;

	typedef enum logic [1:0] {
		CYC_READ,
		CYC_WRITE,
		CYC_DUMMY
	} cycle_kind_type;

	typedef struct packed {
		cycle_kind_type kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] byte_en;
	} bus_req_type;

	typedef struct packed {
		logic read_n;
		logic write_lo_n;
		logic upper_byte_write_strobe_n;
		logic dir_read;
		logic row_strobe_n;
		logic [NUM_SEL-1:0] select_n;
	} strobe_type;

	localparam strobe_type STROBE_IDLE = '{
		read_n: 1'b1,
		write_lo_n: 1'b1,
		upper_byte_write_strobe_n: 1'b1,
		dir_read: 1'b1,
		row_strobe_n: 1'b1,
		select_n: 3'h7
	};
endpackage : ext_bus_pkg

// >>> test/ext_mem_model.sv
// partner model: external memory answering the strobes, able to stretch cycles
`timescale 1ns/1ps
module ext_mem_model (
	// clock
	input wire logic clk_sys,
	// pins from the block
	input wire ext_bus_pkg::strobe_type strobe,
	input wire logic [ext_bus_pkg::ADDR_W-1:0] address_lines,
	input wire logic [ext_bus_pkg::DATA_W-1:0] data_out,
	// pins to the block
	output logic [ext_bus_pkg::DATA_W-1:0] data_in,
	output logic wait_n,
	// stretch length in cycles
	input wire logic [3:0] stall
);
	logic [15:0] mem [int];
	logic [15:0] last = 16'h0000;
	logic [3:0] cnt = 4'h0;
	// a slow device holds wait low for stall cycles from the moment it is armed;
	// the block sees the pin four edges late, so wait has to lead the strobes
	assign wait_n = !(stall != 4'h0 && cnt < stall);
	// a released bus shows the inverse of the last value, never a stale copy
	assign data_in = !strobe.read_n ? mem[int'(address_lines)] : ~last;
	always @(posedge clk_sys) begin
		cnt <= (stall == 4'h0) ? 4'h0 : ((cnt < stall) ? cnt + 4'h1 : cnt);
		if (!strobe.read_n)
			last <= data_in;
		if (!strobe.write_lo_n)
			mem[int'(address_lines)][7:0] <= data_out[7:0];
		if (!strobe.upper_byte_write_strobe_n)
			mem[int'(address_lines)][15:8] <= data_out[15:8];
	end
endmodule : ext_mem_model

// >>> test/external_bus_pin_interface_tb_top.sv
// testbench: bus cycles, byte lanes, selects, wait stretch and bus hold
`timescale 1ns/1ps
module external_bus_pin_interface_tb_top;
	logic clk_sys = 1'b0, reset_n = 1'b0, req_valid = 1'b0, foreign_valid = 1'b0;
	logic bus_hold_request_n = 1'b1, clk_en = 1'b1;
	logic [2:0] dram_mode = 3'h0;
	logic [3:0] stall = 4'h0;
	logic [23:0] foreign_addr = 24'h00_0000, a;
	ext_bus_pkg::bus_req_type req = '0;
	logic req_ready, done, bus_hold_grant_n, strobe_oe, address_oe, data_oe, refused, wait_n;
	logic [15:0] rdata, data_in, data_out, d;
	logic [23:0] address_lines;
	ext_bus_pkg::strobe_type strobe, seen;
	int miscompares = 0, samples_checked = 0, lat;
	logic [15:0] model [int];
	logic [23:0] areas [3] = '{24'h01_0010, 24'h20_0020, 24'h80_0030};
	logic [1:0] bes [3] = '{2'h1, 2'h2, 2'h3};
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) seen <= seen & strobe;
	external_bus_pin_interface u_external_bus_pin_interface (.clk_sys(clk_sys),
		.reset_n(reset_n), .clk_en(clk_en), .dram_mode(dram_mode), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .done(done), .rdata(rdata), .wait_n(wait_n),
		.bus_hold_request_n(bus_hold_request_n), .bus_hold_grant_n(bus_hold_grant_n),
		.strobe(strobe), .strobe_oe(strobe_oe), .address_lines(address_lines),
		.address_oe(address_oe), .muxed_addr_data_bus_in(data_in),
		.muxed_addr_data_bus_out(data_out), .muxed_addr_data_bus_oe(data_oe),
		.foreign_addr(foreign_addr), .foreign_valid(foreign_valid), .foreign_refused(refused));
	ext_mem_model u_ext_mem_model (.clk_sys(clk_sys), .strobe(strobe),
		.address_lines(address_lines), .data_out(data_out), .data_in(data_in),
		.wait_n(wait_n), .stall(stall));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task automatic op(input ext_bus_pkg::cycle_kind_type k, input logic [23:0] ad,
		input logic [15:0] wd, input logic [1:0] be);
		int n;
		n = 0;
		// ready only shows idle with nothing pending, so the next edge takes the request
		while (req_ready !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 50)
			check(16'h0000, 16'h0001, "never ready");
		req = '{kind: k, addr: ad, wdata: wd, byte_en: be};
		req_valid = 1'b1;
		seen = '1;
		@(posedge clk_sys);
		#1;
		req_valid = 1'b0;
		lat = 0;
		while (done !== 1'b1 && lat < 60) begin
			@(posedge clk_sys);
			#1;
			lat++;
		end
		if (lat >= 60)
			check(16'h0000, 16'h0001, "no done");
		if (be[0] && k == ext_bus_pkg::CYC_WRITE)
			model[int'(ad)][7:0] = wd[7:0];
		if (be[1] && k == ext_bus_pkg::CYC_WRITE)
			model[int'(ad)][15:8] = wd[15:8];
	endtask : op
	task automatic foreign(input logic [23:0] ad, input logic exp);
		logic got;
		got = 1'b0;
		foreign_addr = ad;
		foreign_valid = 1'b1;
		repeat (4) begin
			@(posedge clk_sys);
			#1;
			foreign_valid = 1'b0;
			got = got | refused;
		end
		check(16'(got), 16'(exp), "refusal");
	endtask : foreign
	task automatic wait_grant(input logic lvl);
		int n;
		n = 0;
		while (bus_hold_grant_n !== lvl && n < 30) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 30)
			check(16'h0000, 16'h0001, "grant never changed");
	endtask : wait_grant
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h3926));
		repeat (5) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		for (int i = 0; i < 6; i++) begin
			a = areas[i % 3] + 24'(2 * i);
			d = 16'($urandom);
			op(ext_bus_pkg::CYC_WRITE, a, ~d, 2'h3);
			op(ext_bus_pkg::CYC_WRITE, a, d, bes[i % 3]);
			check(16'(seen.select_n), 16'(~(3'h1 << (i % 3)) & 3'h7), "select");
			check({seen.write_lo_n, seen.upper_byte_write_strobe_n, seen.read_n, seen.dir_read},
				{~bes[i % 3][0], ~bes[i % 3][1], 2'b10}, "write strobes");
			check(16'(lat), 16'(2 + ext_bus_pkg::WAIT_DEFAULT), "latency");
			op(ext_bus_pkg::CYC_READ, a, 16'h0000, 2'h3);
			check(rdata, model[int'(a)], "read data");
			check({seen.read_n, seen.write_lo_n, seen.upper_byte_write_strobe_n, seen.dir_read},
				4'b0111, "read strobes");
		end
		op(ext_bus_pkg::CYC_DUMMY, a, 16'h0000, 2'h0);
		check({seen.read_n, seen.write_lo_n, seen.dir_read}, 3'b111, "dummy");
		stall = 4'h5;
		op(ext_bus_pkg::CYC_READ, a, 16'h0000, 2'h3);
		check(16'(lat > 2 + ext_bus_pkg::WAIT_DEFAULT), 16'h0001, "stretch");
		check(rdata, model[int'(a)], "stretched read");
		stall = 4'h0;
		dram_mode = 3'h7;
		for (int i = 0; i < 3; i++) begin
			op(ext_bus_pkg::CYC_READ, areas[i % 3] + 24'(2 * i), 16'h0000, 2'h3);
			check({seen.row_strobe_n, seen.select_n[i]}, 2'b00, "dram strobes");
		end
		dram_mode = 3'h0;
		bus_hold_request_n = 1'b0;
		wait_grant(1'b0);
		check({strobe_oe, address_oe, data_oe, bus_hold_grant_n}, 4'h0, "float");
		foreign(24'h00_0800, 1'b1);
		foreign(24'h01_0000, 1'b0);
		check(16'(bus_hold_grant_n), 16'h0000, "grant held");
		// withdraw the request while frozen: nothing may move until the enable returns
		clk_en = 1'b0;
		bus_hold_request_n = 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		check({strobe_oe, address_oe, bus_hold_grant_n}, 3'b000, "frozen hold");
		clk_en = 1'b1;
		wait_grant(1'b1);
		// grant rises one edge before the pins are driven again
		@(posedge clk_sys);
		#1;
		check({strobe_oe, address_oe, bus_hold_grant_n}, 3'b111, "resume");
		end_of_test();
	end
endmodule : external_bus_pin_interface_tb_top
